// ### design/wese_top.sv
// Wake event status and enable block with AHB-Lite register port.
// Assumes rst_b is the standby-power reset; other resets arrive as
// same-clock levels; interrupt and acknowledge inputs are async pins.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module wese_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Internal event sources, asynchronous
	input  wire logic        serial2Irq,
	input  wire logic        serial1Irq,
	input  wire logic        floppyIrq,
	input  wire logic        mouseIrq,
	input  wire logic        keyboardIrq,
	input  wire logic        watchdogEvent,
	input  wire logic        mgmtBusEvent,
	input  wire logic        printerAckN,
	// Other resets, same clock, active high levels
	input  wire logic        mainPowerReset,
	input  wire logic        hardReset,
	input  wire logic        softReset,
	// Wake status of paired sources, same clock
	input  wire logic [7:0]  portWakeSts,
	input  wire logic [7:0]  gpio1xWakeSts,
	input  wire logic [7:0]  gpio2xWakeSts,
	// Outputs
	output logic             wakeOutN,
	output logic             irq
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [7:0] srcRaw;
	logic [7:0] srcSync;

	always_comb begin
		srcRaw = '0;
		srcRaw[wese_pkg::STS_PARALLEL_PORT_IRQ] = printerAckN;
		srcRaw[wese_pkg::STS_SERIAL2_IRQ]       = serial2Irq;
		srcRaw[wese_pkg::STS_SERIAL1_IRQ]       = serial1Irq;
		srcRaw[wese_pkg::STS_FLOPPY_IRQ]        = floppyIrq;
		srcRaw[wese_pkg::STS_MOUSE_IRQ]         = mouseIrq;
		srcRaw[wese_pkg::STS_KEYBOARD_IRQ]      = keyboardIrq;
		srcRaw[wese_pkg::STS_WATCHDOG_EVENT]    = watchdogEvent;
		srcRaw[wese_pkg::STS_MGMT_BUS_EVENT]    = mgmtBusEvent;
	end

	wese_sync #(
		.W (8)
	) u_src_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      (srcRaw),
		.dout     (srcSync)
	);

	// ****************************************************************
	// Address phase capture
	// ****************************************************************
	wese_pkg::wese_aphase_t aphase_reg;
	wese_pkg::wese_aphase_t aphase_next;

	always_comb begin
		aphase_next = '0;
		if (hsel && htrans[1] && hready) begin
			aphase_next.valid = 1'b1;
			aphase_next.write = hwrite;
			aphase_next.word  = haddr[9:2];
			// Only whole aligned words below 1 KiB decode
			aphase_next.hit   = (haddr[31:10] == wese_pkg::ADDR_HIGH_0)
				&& (haddr[1:0] == 2'h0)
				&& (hsize == wese_pkg::HSIZE_WORD);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aphase_reg <= '0;
		end else begin
			aphase_reg <= aphase_next;
		end
	end

	logic       wrEn;
	logic [7:0] wrByte;

	always_comb begin
		wrEn   = aphase_reg.valid && aphase_reg.write && aphase_reg.hit;
		wrByte = hwdata[7:0];
	end

	// ****************************************************************
	// Internal event status, bits 7..1 sticky
	// ****************************************************************
	logic [7:1] stsSet;
	logic [7:1] stsClr;
	logic [7:1] stsFlags;
	logic [7:1] stsFlagsNext;

	always_comb begin
		stsSet = srcSync[7:1];
		stsClr = '0;
		if (wrEn && aphase_reg.word == wese_pkg::IDX_INTERNAL_EVENT_STATUS) begin
			stsClr = wrByte[7:1];
		end
	end

	// Of the resets only rst_b clears these; other resets never reach them
	wese_w1c_bits #(
		.W   (7),
		.RST (wese_pkg::INTERNAL_EVENT_STATUS_RST[7:1])
	) u_sts_bits (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.setBits   (stsSet),
		.clrBits   (stsClr),
		.flags     (stsFlags),
		.flagsNext (stsFlagsNext)
	);

	// ****************************************************************
	// Status bit 0, parallel port level
	// ****************************************************************
	wese_pkg::wese_ctrl_t ctrl_reg;
	wese_pkg::wese_ctrl_t ctrl_next;
	logic ppBit_reg;
	logic ppBit_next;
	logic forceBit0;

	// A live level, so a one-write has no lasting effect here
	always_comb begin
		forceBit0  = mainPowerReset || hardReset || softReset;
		ppBit_next = forceBit0
			|| !ctrl_reg.ppActivate
			|| srcSync[wese_pkg::STS_PARALLEL_PORT_IRQ];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ppBit_reg <= wese_pkg::INTERNAL_EVENT_STATUS_RST[0];
		end else begin
			ppBit_reg <= ppBit_next;
		end
	end

	// ****************************************************************
	// Enable and control registers
	// ****************************************************************
	wese_pkg::wese_wake_en_t en_reg;
	wese_pkg::wese_wake_en_t en_next;
	logic [1:0] mask_reg;
	logic [1:0] mask_next;

	always_comb begin
		en_next   = en_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		if (wrEn) begin
			if (aphase_reg.word == wese_pkg::IDX_WAKE_ENABLE_PORTS) begin
				en_next.ports = wrByte;
			end else if (aphase_reg.word == wese_pkg::IDX_WAKE_ENABLE_GPIO_1X) begin
				en_next.gpio1x = wrByte;
			end else if (aphase_reg.word == wese_pkg::IDX_WAKE_ENABLE_GPIO_2X) begin
				en_next.gpio2x = wrByte;
			end else if (aphase_reg.word == wese_pkg::IDX_WAKE_CONTROL) begin
				ctrl_next = wrByte[1:0];
			end else if (aphase_reg.word == wese_pkg::IDX_IRQ_MASK) begin
				mask_next = wrByte[1:0];
			end
		end
	end

	// Other resets are not wired here on purpose
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_reg   <= {3{wese_pkg::WAKE_ENABLE_RST}};
			ctrl_reg <= wese_pkg::WAKE_CONTROL_RST;
			mask_reg <= wese_pkg::IRQ_MASK_RST;
		end else begin
			en_reg   <= en_next;
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
		end
	end

	// ****************************************************************
	// Wake output
	// ****************************************************************
	logic wakeOutN_reg;
	logic wakeOutN_next;
	logic wakeAny;

	// Status feeds in whatever the enables hold; gating is here only
	always_comb begin
		wakeAny = |(en_reg.ports & portWakeSts)
			| |(en_reg.gpio1x & gpio1xWakeSts)
			| |(en_reg.gpio2x & gpio2xWakeSts);
		wakeOutN_next = !(ctrl_reg.masterWakeEnable && wakeAny);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wakeOutN_reg <= 1'b1;
		end else begin
			wakeOutN_reg <= wakeOutN_next;
		end
	end

	// ****************************************************************
	// Interrupt status and output
	// ****************************************************************
	logic [1:0] intSet;
	logic [1:0] intClr;
	logic [1:0] intFlags;
	logic [1:0] intFlagsNext;
	logic       irq_reg;
	logic       irq_next;

	always_comb begin
		intSet = '0;
		intSet[wese_pkg::IRQ_INTERNAL_EVENT] = |(stsSet & ~stsFlags);
		intSet[wese_pkg::IRQ_WAKE_ASSERTED]  = wakeOutN_reg && !wakeOutN_next;
		intClr = '0;
		if (wrEn && aphase_reg.word == wese_pkg::IDX_IRQ_STATUS) begin
			intClr = wrByte[1:0];
		end
	end

	wese_w1c_bits #(
		.W   (2),
		.RST (wese_pkg::IRQ_STATUS_RST)
	) u_int_bits (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.setBits   (intSet),
		.clrBits   (intClr),
		.flags     (intFlags),
		.flagsNext (intFlagsNext)
	);

	always_comb begin
		irq_next = |(intFlagsNext & mask_next);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic        hready_reg;

	// Reads see next values so a write just before is never stale
	always_comb begin
		hrdata_next = '0;
		if (aphase_next.valid && !aphase_next.write && aphase_next.hit) begin
			if (aphase_next.word == wese_pkg::IDX_INTERNAL_EVENT_STATUS) begin
				hrdata_next[7:0] = {stsFlagsNext, ppBit_next};
			end else if (aphase_next.word == wese_pkg::IDX_WAKE_ENABLE_PORTS) begin
				hrdata_next[7:0] = en_next.ports;
			end else if (aphase_next.word == wese_pkg::IDX_WAKE_ENABLE_GPIO_1X) begin
				hrdata_next[7:0] = en_next.gpio1x;
			end else if (aphase_next.word == wese_pkg::IDX_WAKE_ENABLE_GPIO_2X) begin
				hrdata_next[7:0] = en_next.gpio2x;
			end else if (aphase_next.word == wese_pkg::IDX_WAKE_CONTROL) begin
				hrdata_next[1:0] = ctrl_next;
			end else if (aphase_next.word == wese_pkg::IDX_IRQ_STATUS) begin
				hrdata_next[1:0] = intFlagsNext;
			end else if (aphase_next.word == wese_pkg::IDX_IRQ_MASK) begin
				hrdata_next[1:0] = mask_next;
			end
		end
	end

	// Zero wait states; every access answers OKAY
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata_reg <= '0;
			hready_reg <= 1'b1;
		end else begin
			hrdata_reg <= hrdata_next;
			hready_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign hrdata    = hrdata_reg;
	assign hreadyout = hready_reg;
	assign hresp     = 1'b0;
	assign wakeOutN  = wakeOutN_reg;
	assign irq       = irq_reg;

endmodule : wese_top

`default_nettype wire

// ### design/wese_pkg.sv
// Offsets, field positions, reset values and carriers for the wake block.
// Assumes one 40 MHz clock and a 32-bit AHB-Lite register port.
package wese_pkg;

	// ****************************************************************
	// Register word indexes; byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] IDX_INTERNAL_EVENT_STATUS = 8'h09;
	localparam logic [7:0] IDX_WAKE_ENABLE_PORTS     = 8'h0A;
	localparam logic [7:0] IDX_WAKE_ENABLE_GPIO_1X   = 8'h0B;
	localparam logic [7:0] IDX_WAKE_ENABLE_GPIO_2X   = 8'h0C;
	localparam logic [7:0] IDX_WAKE_CONTROL          = 8'h10;
	localparam logic [7:0] IDX_IRQ_STATUS            = 8'h11;
	localparam logic [7:0] IDX_IRQ_MASK              = 8'h12;

	// ****************************************************************
	// Reset values, all taken on standby-power reset
	// ****************************************************************
	localparam logic [7:0] INTERNAL_EVENT_STATUS_RST = 8'h01;
	localparam logic [7:0] WAKE_ENABLE_RST           = 8'h00;
	localparam logic [1:0] WAKE_CONTROL_RST          = 2'h0;
	localparam logic [1:0] IRQ_STATUS_RST            = 2'h0;
	localparam logic [1:0] IRQ_MASK_RST              = 2'h0;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int STS_PARALLEL_PORT_IRQ = 0;
	localparam int STS_SERIAL2_IRQ       = 1;
	localparam int STS_SERIAL1_IRQ       = 2;
	localparam int STS_FLOPPY_IRQ        = 3;
	localparam int STS_MOUSE_IRQ         = 4;
	localparam int STS_KEYBOARD_IRQ      = 5;
	localparam int STS_WATCHDOG_EVENT    = 6;
	localparam int STS_MGMT_BUS_EVENT    = 7;
	localparam int EN_KBC_PORT_BIT_A     = 0;
	localparam int EN_KBC_PORT_BIT_B     = 1;
	localparam int EN_RING_INDICATOR_1   = 2;
	localparam int EN_KEYBOARD_ACTIVITY  = 3;
	localparam int EN_MOUSE_ACTIVITY     = 4;
	localparam int EN_SPECIFIC_KEY_WAKE  = 5;
	localparam int EN_EVENT_A            = 6;
	localparam int EN_RING_INDICATOR_2   = 7;
	localparam int IRQ_INTERNAL_EVENT    = 0;
	localparam int IRQ_WAKE_ASSERTED     = 1;

	// ****************************************************************
	// Bus constants
	// ****************************************************************
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;
	localparam logic [21:0] ADDR_HIGH_0 = 22'h000000;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       hit;
		logic [7:0] word;
	} wese_aphase_t;

	typedef struct packed {
		logic [7:0] gpio2x;
		logic [7:0] gpio1x;
		logic [7:0] ports;
	} wese_wake_en_t;

	typedef struct packed {
		logic ppActivate;
		logic masterWakeEnable;
	} wese_ctrl_t;

endpackage : wese_pkg

// ### design/wese_sync.sv
// Two-flop synchroniser for a vector of unrelated levels.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps
`default_nettype none

module wese_sync #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ****************************************************************
	// Two stages
	// ****************************************************************
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = din;
		sync_next = meta_reg;
	end

	// First stage feeds only the second one
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign dout = sync_reg;

endmodule : wese_sync

`default_nettype wire

// ### design/wese_w1c_bits.sv
// Sticky flags, set by hardware, cleared by writing one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module wese_w1c_bits #(
	parameter int           W   = 8,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] setBits,
	input  wire logic [W-1:0] clrBits,
	output logic      [W-1:0] flags,
	output logic      [W-1:0] flagsNext
);

	// ****************************************************************
	// Flags
	// ****************************************************************
	logic [W-1:0] flags_reg;

	// Set wins over a clear in the same cycle so no event is lost
	always_comb begin
		flagsNext = (flags_reg & ~clrBits) | setBits;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_reg <= RST;
		end else begin
			flags_reg <= flagsNext;
		end
	end

	assign flags = flags_reg;

endmodule : wese_w1c_bits

`default_nettype wire

// ### tb/wese_assertions.sv
// Port checker for the wake status and enable block.
// Assumes one clock, rst_b as its only asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module wese_assertions (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        mainPowerReset,
	input wire logic        hardReset,
	input wire logic        softReset,
	input wire logic [7:0]  portWakeSts,
	input wire logic [7:0]  gpio1xWakeSts,
	input wire logic [7:0]  gpio2xWakeSts,
	input wire logic        wakeOutN,
	input wire logic        irq
);
	// ****************************************************************
	// Helper terms
	// ****************************************************************
	logic taken;
	logic rdTaken;
	logic wrTaken;
	logic inMap;
	logic anySrc;
	logic rstLevel;
	logic stsRead;
	assign taken    = hsel && htrans[1] && hready;
	assign rdTaken  = taken && !hwrite;
	assign wrTaken  = taken && hwrite;
	assign inMap    = haddr[9:2] inside {8'h09, 8'h0A, 8'h0B, 8'h0C,
		8'h10, 8'h11, 8'h12};
	assign anySrc   = |{portWakeSts, gpio1xWakeSts, gpio2xWakeSts};
	assign rstLevel = mainPowerReset || hardReset || softReset;
	assign stsRead  = rdTaken && haddr == 32'h00000024;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_resp_okay;
		hresp == 1'b0;
	endproperty
	a_resp_okay: assert property (p_resp_okay)
		else $error("hresp not OKAY");
	property p_ready;
		hreadyout == 1'b1;
	endproperty
	a_ready: assert property (p_ready)
		else $error("hreadyout low");
	property p_upper_zero;
		hrdata[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("hrdata upper bits set");
	property p_unmapped;
		rdTaken && !inMap |=> hrdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_write_quiet;
		wrTaken |=> hrdata == 32'h00000000;
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("hrdata set in write data phase");
	property p_no_src_no_wake;
		!anySrc |=> wakeOutN;
	endproperty
	a_no_src_no_wake: assert property (p_no_src_no_wake)
		else $error("wake low with no source");
	property p_wake_needs_src;
		$fell(wakeOutN) |-> $past(anySrc);
	endproperty
	a_wake_needs_src: assert property (p_wake_needs_src)
		else $error("wake fell without source");
	// Reads return the state after the address edge, so the reset
	// level must stand at that same edge
	property p_reset_bit0;
		rstLevel && stsRead |=> hrdata[0];
	endproperty
	a_reset_bit0: assert property (p_reset_bit0)
		else $error("status bit 0 not forced");

	c_wake: cover property ($fell(wakeOutN));
	c_irq: cover property ($rose(irq));
	c_reset_read: cover property (rstLevel && stsRead);
endmodule : wese_assertions

bind wese_top wese_assertions u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp),
	.mainPowerReset(mainPowerReset), .hardReset(hardReset),
	.softReset(softReset), .portWakeSts(portWakeSts),
	.gpio1xWakeSts(gpio1xWakeSts), .gpio2xWakeSts(gpio2xWakeSts),
	.wakeOutN(wakeOutN), .irq(irq));
`default_nettype wire

// ### tb/wese_pm_model.sv
// Chipset side that receives the wake request.
// Assumes wakeOutN is a level on the same clock.
`timescale 1ns/1ps
`default_nettype none

module wese_pm_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic wakeOutN,
	output int        wakeCount
);
	logic seenLow;
	// Counts each new wake request, not the cycles it stands
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			seenLow   <= 1'b0;
			wakeCount <= 0;
		end else begin
			seenLow <= !wakeOutN;
			if (!wakeOutN && !seenLow) begin
				wakeCount <= wakeCount + 1;
			end
		end
	end
endmodule : wese_pm_model
`default_nettype wire

// ### tb/wake_event_status_enable_test.sv
// Self-checking bench for the wake status and enable block.
// Assumes wese_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module wake_event_status_enable_test;
	logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, stsM, ctrlM;
	logic [1:0]  htrans;
	logic [2:0]  hsize, otherRst;
	logic [6:0]  src;
	logic        printerAckN, wakeOutN, irq;
	logic [23:0] wakeSts, enM;
	logic [7:0]  rIdx [0:5];
	int          fail_count, n_tests, cycles, wakeCount, i;
	integer      seed;

	wese_top DUT (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial2Irq(src[0]),
		.serial1Irq(src[1]), .floppyIrq(src[2]), .mouseIrq(src[3]),
		.keyboardIrq(src[4]), .watchdogEvent(src[5]),
		.mgmtBusEvent(src[6]), .printerAckN(printerAckN),
		.mainPowerReset(otherRst[0]), .hardReset(otherRst[1]),
		.softReset(otherRst[2]), .portWakeSts(wakeSts[7:0]),
		.gpio1xWakeSts(wakeSts[15:8]), .gpio2xWakeSts(wakeSts[23:16]),
		.wakeOutN(wakeOutN), .irq(irq));
	wese_pm_model u_pm (.core_clk(core_clk), .rst_b(rst_b),
		.wakeOutN(wakeOutN), .wakeCount(wakeCount));

	// ****************************************************************
	// Bus cycles and comparisons
	// ****************************************************************
	task automatic bus(input logic w, input logic [7:0] idx,
			input logic [31:0] d);
		@(posedge core_clk);
		haddr  <= {22'h000000, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdChk(input string n, input logic [31:0] e);
		n_tests++;
		if (rd !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, rd);
		end
	endtask : rdChk

	task automatic pinChk(input string n, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : pinChk

	task automatic setEn(input logic [23:0] e);
		int k;
		enM = e;
		for (k = 0; k < 3; k++) begin
			bus(1'b1, 8'(wese_pkg::IDX_WAKE_ENABLE_PORTS + k),
				32'(e[8*k +: 8]));
		end
	endtask : setEn

	task automatic pulseSrc(input logic [6:0] s);
		src <= s;
		repeat (5) @(posedge core_clk);
		src <= 7'h00;
	endtask : pulseSrc

	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	function automatic logic wakeE;
		return !(ctrlM[0] && |(enM & wakeSts));
	endfunction : wakeE

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Hang guard, far above the thousand or so cycles needed
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		{rst_b, hwrite, htrans, haddr, hwdata, otherRst, src} = '0;
		{hsel, printerAckN, hsize} = {1'b1, 1'b1, 3'h2};
		{wakeSts, fail_count, n_tests, cycles} = '0;
		seed = 32'hB3B0;
		rIdx = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h10, 8'h05};
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 6; i++) begin
			bus(1'b0, rIdx[i], 32'h0);
			rdChk("reset value", (i == 0) ? 32'h01 : 32'h00);
		end
		// Events recorded with every enable and master bit clear
		stsM = 32'h01;
		for (i = 1; i < 8; i++) begin
			pulseSrc(7'(1 << (i - 1)));
			stsM[i] = 1'b1;
			bus(1'b0, 8'h09, 32'h0);
			rdChk("status", stsM);
		end
		hwdata <= 32'($random(seed));
		bus(1'b1, 8'h09, 32'($random(seed)) & 32'hFF);
		stsM = (stsM & ~hwdata) | 32'h01;
		bus(1'b0, 8'h09, 32'h0);
		rdChk("status after clear", stsM);
		bus(1'b1, 8'h09, 32'h0);
		bus(1'b0, 8'h09, 32'h0);
		rdChk("status after zero write", stsM);
		bus(1'b1, 8'h09, 32'hFF);
		// Every enable bit alone, then random mixes with master random
		for (i = 0; i < 40; i++) begin
			ctrlM = (i < 24) ? 32'h1 : 32'($random(seed)) & 32'h1;
			bus(1'b1, 8'h10, ctrlM);
			setEn((i < 24) ? 24'(1 << i) : 24'($random(seed)));
			wakeSts <= (i < 24) ? ~enM : 24'($random(seed));
			repeat (3) @(posedge core_clk);
			pinChk("wake masked", wakeE(), wakeOutN);
			wakeSts <= enM;
			repeat (3) @(posedge core_clk);
			pinChk("wake", wakeE(), wakeOutN);
		end
		wakeSts <= 24'h000000;
		// Both interrupt causes have fired by now
		bus(1'b0, 8'h11, 32'h0);
		rdChk("irq status after wake", 32'h3);
		// Interrupt: clear stale, raise, clear, then masked
		bus(1'b1, 8'h11, 32'h3);
		bus(1'b1, 8'h12, 32'h1);
		pinChk("irq idle", 1'b0, irq);
		pulseSrc(7'h40);
		pinChk("irq raised", 1'b1, irq);
		bus(1'b1, 8'h11, 32'h3);
		repeat (2) @(posedge core_clk);
		pinChk("irq cleared", 1'b0, irq);
		bus(1'b1, 8'h12, 32'h0);
		pulseSrc(7'h20);
		pinChk("irq masked", 1'b0, irq);
		bus(1'b0, 8'h11, 32'h0);
		rdChk("irq status", 32'h1);
		// Other resets with the port active and acknowledge low
		bus(1'b1, 8'h09, 32'hFF);
		bus(1'b1, 8'h10, 32'h2);
		printerAckN <= 1'b0;
		pulseSrc(7'h01);
		stsM = 32'h02;
		setEn(24'h5AC3A5);
		for (i = 0; i < 3; i++) begin
			otherRst <= 3'(1 << i);
			bus(1'b0, 8'h09, 32'h0);
			rdChk("status in reset", stsM | 32'h1);
			otherRst <= 3'h0;
			repeat (3) @(posedge core_clk);
			bus(1'b0, 8'h09, 32'h0);
			rdChk("status after reset", stsM);
			bus(1'b0, 8'(8'h0A + i), 32'h0);
			rdChk("enable kept", 32'(enM[8*i +: 8]));
		end
		printerAckN <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus(1'b0, 8'h09, 32'h0);
		rdChk("status ack high", stsM | 32'h1);
		// Byte-sized write must be dropped
		hsize <= 3'h0;
		bus(1'b1, 8'h0A, 32'hFF);
		hsize <= 3'h2;
		bus(1'b0, 8'h0A, 32'h0);
		rdChk("byte write ignored", 32'(enM[7:0]));
		pinChk("wake requests seen", 1'b1, wakeCount >= 24);
		tally_and_finish();
	end
endmodule : wake_event_status_enable_test
`default_nettype wire
